// [logic/status_flag_pkg.sv]
// Constants, register map and mode encoding for the system status flag word bank.
// Assumes a single 50 MHz clock and an APB master with 32-bit data and 12-bit byte addresses.
`default_nettype none

package status_flag_pkg;

  // Clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 20;
  // Common timebase tick, in milliseconds; every pulse bit is a whole number of ticks.
  localparam int TICK_MS = 10;
  // Clock cycles in one tick.
  localparam int TICK_CYCLES = (TICK_MS * 1000000) / CLK_PERIOD_NS;

  // Half periods of the square waves, in milliseconds.
  localparam int HALF_1MIN_MS = 30000;
  localparam int HALF_20MS_MS = 10;
  localparam int HALF_100MS_MS = 50;
  localparam int HALF_200MS_MS = 100;
  localparam int HALF_1S_MS = 500;

  // Half periods in ticks, and the length of the whole timebase frame.
  localparam int HALF_1MIN_TK = HALF_1MIN_MS / TICK_MS;
  localparam int HALF_20MS_TK = HALF_20MS_MS / TICK_MS;
  localparam int HALF_100MS_TK = HALF_100MS_MS / TICK_MS;
  localparam int HALF_200MS_TK = HALF_200MS_MS / TICK_MS;
  localparam int HALF_1S_TK = HALF_1S_MS / TICK_MS;
  localparam int FRAME_TK = 2 * HALF_1MIN_TK;

  // Word indices; the byte address is four times the index.
  localparam int IDX_CONTROL = 252;
  localparam int IDX_ERROR = 253;
  localparam int IDX_INSTR = 254;
  localparam int IDX_ARITH = 255;
  localparam int IDX_RETAIN = 256;
  localparam int IDX_SUPPRESS = 257;
  localparam int IDX_FORCE_SET = 258;
  localparam int IDX_FORCE_RST = 259;
  localparam int IDX_RO_LOW = 248;
  localparam logic [11:0] ADDR_CONTROL = 12'(IDX_CONTROL * 4);
  localparam logic [11:0] ADDR_ERROR = 12'(IDX_ERROR * 4);
  localparam logic [11:0] ADDR_INSTR = 12'(IDX_INSTR * 4);
  localparam logic [11:0] ADDR_ARITH = 12'(IDX_ARITH * 4);
  localparam logic [11:0] ADDR_RETAIN = 12'(IDX_RETAIN * 4);
  localparam logic [11:0] ADDR_SUPPRESS = 12'(IDX_SUPPRESS * 4);
  localparam logic [11:0] ADDR_FORCE_SET = 12'(IDX_FORCE_SET * 4);
  localparam logic [11:0] ADDR_FORCE_RST = 12'(IDX_FORCE_RST * 4);
  localparam logic [11:0] ADDR_RO_LOW = 12'(IDX_RO_LOW * 4);

  // Field positions.
  localparam int BIT_FORCE_HOLD = 11;
  localparam int BIT_IO_HOLD = 12;
  localparam int BIT_OUT_OFF = 15;
  localparam int BIT_BATT_LOW = 8;
  localparam int BIT_OVERRUN = 9;
  localparam int BIT_SUP_BATT = 0;
  localparam int BIT_SUP_OVERRUN = 1;
  localparam int BIT_RETAIN = 0;

  // Reset values.
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_CODE = 8'h00;
  // Square waves start in their high half.
  localparam logic [4:0] RST_PULSE = 5'h1f;
  // Alarm code reported for a pulse I/O or absolute counter error.
  localparam logic [7:0] PULSE_IO_ALARM = 8'h9c;

  // Operating modes, one-hot.
  typedef enum logic [2:0] {
    MODE_PROGRAM = 3'b001,
    MODE_MONITOR = 3'b010,
    MODE_RUN = 3'b100
  } run_mode_t;

endpackage : status_flag_pkg

`default_nettype wire

// [logic/status_flag_words.sv]
// System status flag word bank with APB register access, pulse timebase and output control.
// Assumes flag inputs come from logic on pclk, except battery_low_pin, which is a raw pin.
`default_nettype none

module status_flag_words
  import status_flag_pkg::*;
#(
  parameter int TICK_LEN = status_flag_pkg::TICK_CYCLES // Clock cycles per timebase tick.
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire status_flag_pkg::run_mode_t mode_sel, // Current operating mode.
  input wire logic power_up_evt, // Power restored pulse.
  input wire logic scan_end, // End of program scan pulse.
  input wire logic flag_update, // Instruction result flags valid.
  input wire logic overflow_in, // Signed overflow of result.
  input wire logic underflow_in, // Signed underflow of result.
  input wire logic exec_error_in, // Instruction execution error.
  input wire logic carry_in, // Carry out of result.
  input wire logic greater_in, // Comparison gave greater.
  input wire logic equal_in, // Comparison gave equal.
  input wire logic less_in, // Comparison gave less.
  input wire logic result_zero_in, // Result is zero.
  input wire logic diff_mon_start, // Differential monitoring starts.
  input wire logic diff_mon_done, // Differential monitoring finished.
  input wire logic step_start, // Step process starts.
  input wire logic hex_keypad_active, // Keypad instruction executing.
  input wire logic seven_segment_active, // Display instruction executing.
  input wire logic digit_switch_active, // Switch instruction executing.
  input wire logic pulse_io_error, // Pulse I/O or counter error pulse.
  input wire logic error_clear, // Clear latched errors.
  input wire logic battery_low_pin, // Raw battery low level.
  input wire logic cycle_overrun, // Cycle time overrun pulse.
  input wire logic prog_out_we, // Program writes output image.
  input wire logic [15:0] prog_out, // Program output value.
  output logic [15:0] out_pins, // Physical outputs.
  output logic inhibit_indicator, // Output inhibit lamp.
  output logic io_area_reset, // I/O and link area reset pulse.
  output logic [7:0] fatal_alarm_code // Fatal alarm code.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [18:0] div_reg; // Clock cycles within the current tick.
  logic tick; // One cycle per tick.
  logic [12:0] tick_cnt_reg; // Ticks within the one-minute frame.
  logic [4:0] pulse_reg; // Square waves: 1 min, 20 ms, 100 ms, 200 ms, 1 s.
  logic ovf_reg, unf_reg, diff_reg, step_reg; // Instruction word flags.
  logic [2:0] busy_reg; // Keypad, display, switch busy.
  logic pio_err_reg; // Pulse I/O error latch.
  logic err_reg, carry_reg, gt_reg, eq_reg, lt_reg; // Result flags.
  logic batt_s1_reg, batt_s2_reg; // Battery pin synchroniser.
  logic batt_reg, overrun_reg; // Error word flags.
  logic [15:0] ctrl_reg; // Control word with hold and output-off bits.
  logic retain_reg; // Hold bit retention setting.
  logic [1:0] suppress_reg; // Error suppression setting.
  logic [15:0] fset_reg, frst_reg; // Force set and force reset masks.
  logic [15:0] image_reg; // Output image.
  run_mode_t mode_reg; // Previous mode.
  logic wr, rd; // APB write and read strobes.
  logic mapped; // Address decodes to a word.
  logic entering_run, prog_to_mon, start_stop; // Mode transitions.
  logic force_clear; // Release all forcing.
  logic [15:0] instr_word, arith_word, error_word; // Assembled read words.

  ////////////////////////////////////////////////////////////////////////////////
  // Address decoding helper.

  // Returns a word's register value, or zero for an address that holds none.
  function automatic logic [15:0] word_at(input logic [11:0] a, input logic [15:0] c, input logic [15:0] e,
                                          input logic [15:0] i, input logic [15:0] r, input logic rt,
                                          input logic [1:0] s, input logic [15:0] fs, input logic [15:0] fr);
    logic [15:0] v;
    v = 16'h0000;
    if (a == ADDR_CONTROL) begin
      v = c;
    end else if (a == ADDR_ERROR) begin
      v = e;
    end else if (a == ADDR_INSTR) begin
      v = i;
    end else if (a == ADDR_ARITH) begin
      v = r;
    end else if (a == ADDR_RETAIN) begin
      v = {15'h0000, rt};
    end else if (a == ADDR_SUPPRESS) begin
      v = {14'h0000, s};
    end else if (a == ADDR_FORCE_SET) begin
      v = fs;
    end else if (a == ADDR_FORCE_RST) begin
      v = fr;
    end
    return v;
  endfunction : word_at

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data loaded in the setup cycle.

  // Words 248 to 259 are mapped; 248 to 251 read zero and ignore writes.
  assign mapped = (paddr[1:0] == 2'h0) && (paddr >= ADDR_RO_LOW) && (paddr <= ADDR_FORCE_RST);
  assign wr = psel && penable && pwrite && mapped;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Read data register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd) begin
      prdata <= {16'h0000, word_at(paddr, ctrl_reg, error_word, instr_word, arith_word, retain_reg, suppress_reg,
                                   fset_reg, frst_reg)};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Common timebase and square waves.

  assign tick = (div_reg == 19'(TICK_LEN - 1));

  // Free-running divider and tick counter, independent of the scan.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 19'h00000;
      tick_cnt_reg <= 13'h0000;
    end else if (tick) begin
      div_reg <= 19'h00000;
      tick_cnt_reg <= (tick_cnt_reg == 13'(FRAME_TK - 1)) ? 13'h0000 : tick_cnt_reg + 13'h0001;
    end else begin
      div_reg <= div_reg + 19'h00001;
    end
  end

  // Each wave is high in the first half of its period within the frame.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_reg <= RST_PULSE;
    end else begin
      pulse_reg[0] <= tick_cnt_reg < 13'(HALF_1MIN_TK);
      pulse_reg[1] <= (tick_cnt_reg % 13'(2 * HALF_20MS_TK)) < 13'(HALF_20MS_TK);
      pulse_reg[2] <= (tick_cnt_reg % 13'(2 * HALF_100MS_TK)) < 13'(HALF_100MS_TK);
      pulse_reg[3] <= (tick_cnt_reg % 13'(2 * HALF_200MS_TK)) < 13'(HALF_200MS_TK);
      pulse_reg[4] <= (tick_cnt_reg % 13'(2 * HALF_1S_TK)) < 13'(HALF_1S_TK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction unit flags.

  // Result flags are replaced together each time an instruction reports them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ovf_reg, unf_reg, err_reg, carry_reg, gt_reg, eq_reg, lt_reg} <= 7'h00;
    end else if (flag_update) begin
      ovf_reg <= overflow_in;
      unf_reg <= underflow_in;
      err_reg <= exec_error_in;
      carry_reg <= carry_in;
      gt_reg <= greater_in;
      eq_reg <= equal_in || result_zero_in;
      lt_reg <= less_in;
    end
  end

  // Done stays set until the next monitoring start; a finish in the same cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diff_reg <= 1'b0;
    end else if (diff_mon_done) begin
      diff_reg <= 1'b1;
    end else if (diff_mon_start) begin
      diff_reg <= 1'b0;
    end
  end

  // Step flag rises on a start and falls at the end of that scan.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_reg <= 1'b0;
    end else if (step_start) begin
      step_reg <= 1'b1;
    end else if (scan_end) begin
      step_reg <= 1'b0;
    end
  end

  // Busy bits follow the executing instructions.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 3'h0;
    end else begin
      busy_reg <= {digit_switch_active, seven_segment_active, hex_keypad_active};
    end
  end

  // Pulse I/O error latches with its alarm code; a new error beats a clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pio_err_reg <= 1'b0;
      fatal_alarm_code <= RST_CODE;
    end else if (pulse_io_error) begin
      pio_err_reg <= 1'b1;
      fatal_alarm_code <= PULSE_IO_ALARM;
    end else if (error_clear) begin
      pio_err_reg <= 1'b0;
      fatal_alarm_code <= RST_CODE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Error word with suppression.

  // Two flip-flops before the battery pin is used.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      batt_s1_reg <= 1'b0;
      batt_s2_reg <= 1'b0;
    end else begin
      batt_s1_reg <= battery_low_pin;
      batt_s2_reg <= batt_s1_reg;
    end
  end

  // Battery follows the pin and overrun latches, both unless suppressed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      batt_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      batt_reg <= batt_s2_reg && !suppress_reg[BIT_SUP_BATT];
      if (suppress_reg[BIT_SUP_OVERRUN]) begin
        overrun_reg <= 1'b0;
      end else if (cycle_overrun) begin
        overrun_reg <= 1'b1;
      end else if (error_clear) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read word assembly; writes to these words have no path into them.

  assign instr_word = {pio_err_reg, 4'h0, busy_reg, step_reg, diff_reg, unf_reg, ovf_reg, 2'h0, pulse_reg[1],
                       pulse_reg[0]};
  assign arith_word = {8'h00, lt_reg, eq_reg, gt_reg, carry_reg, err_reg, pulse_reg[4], pulse_reg[3],
                       pulse_reg[2]};
  assign error_word = {6'h00, overrun_reg, batt_reg, fatal_alarm_code};

  ////////////////////////////////////////////////////////////////////////////////
  // Mode tracking and transitions.

  assign entering_run = (mode_sel == MODE_RUN) && (mode_reg != MODE_RUN);
  assign prog_to_mon = (mode_reg == MODE_PROGRAM) && (mode_sel == MODE_MONITOR);
  assign start_stop = (mode_reg == MODE_PROGRAM) != (mode_sel == MODE_PROGRAM);
  assign force_clear = entering_run || (prog_to_mon && !ctrl_reg[BIT_FORCE_HOLD]);

  // Previous mode register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_PROGRAM;
    end else begin
      mode_reg <= mode_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Writable words: control, settings and force masks.

  // Control word; hold bits survive power-up only when retention is set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= RST_WORD;
    end else if (wr && paddr == ADDR_CONTROL) begin
      ctrl_reg <= {pwdata[BIT_OUT_OFF], 2'h0, pwdata[BIT_IO_HOLD], pwdata[BIT_FORCE_HOLD], 11'h000};
    end else if (power_up_evt && !retain_reg) begin
      ctrl_reg[BIT_FORCE_HOLD] <= 1'b0;
      ctrl_reg[BIT_IO_HOLD] <= 1'b0;
    end
  end

  // Retention and suppression settings.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retain_reg <= 1'b0;
      suppress_reg <= 2'h0;
    end else if (wr && paddr == ADDR_RETAIN) begin
      retain_reg <= pwdata[BIT_RETAIN];
    end else if (wr && paddr == ADDR_SUPPRESS) begin
      suppress_reg <= pwdata[1:0];
    end
  end

  // Force masks; a release by mode change beats a write in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fset_reg <= RST_WORD;
      frst_reg <= RST_WORD;
    end else if (force_clear) begin
      fset_reg <= RST_WORD;
      frst_reg <= RST_WORD;
    end else if (wr && paddr == ADDR_FORCE_SET) begin
      fset_reg <= pwdata[15:0];
    end else if (wr && paddr == ADDR_FORCE_RST) begin
      frst_reg <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output image and pins.

  // Forced bits are written into the image, so they stay put once released.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      image_reg <= RST_WORD;
      io_area_reset <= 1'b0;
    end else begin
      io_area_reset <= start_stop && !ctrl_reg[BIT_IO_HOLD];
      if (start_stop && !ctrl_reg[BIT_IO_HOLD]) begin
        image_reg <= RST_WORD;
      end else if (prog_out_we) begin
        image_reg <= (prog_out | fset_reg) & ~(frst_reg & ~fset_reg);
      end else begin
        image_reg <= (image_reg | fset_reg) & ~(frst_reg & ~fset_reg);
      end
    end
  end

  // Output-off blanks every pin regardless of the image.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pins <= RST_WORD;
      inhibit_indicator <= 1'b0;
    end else begin
      out_pins <= ctrl_reg[BIT_OUT_OFF] ? RST_WORD : image_reg;
      inhibit_indicator <= ctrl_reg[BIT_OUT_OFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_wave_phase;
    $rose(pulse_reg[4]) |-> (tick_cnt_reg % 13'(2 * HALF_1S_TK)) == 13'h0000 && $past(tick, 2);
  endproperty
  a_wave_phase: assert property (p_wave_phase) else $error("one-second wave rose off phase");

  property p_fast_wave;
    $changed(pulse_reg[1]) |-> $past(tick, 2) && pulse_reg[1] == !tick_cnt_reg[0];
  endproperty
  a_fast_wave: assert property (p_fast_wave) else $error("fast wave changed off a tick");

  property p_minute_wave;
    $fell(pulse_reg[0]) |-> tick_cnt_reg == 13'(HALF_1MIN_TK) && pulse_reg[4];
  endproperty
  a_minute_wave: assert property (p_minute_wave) else $error("minute wave fell at wrong tick");

  property p_step_once;
    step_reg && scan_end && !step_start |=> !step_reg;
  endproperty
  a_step_once: assert property (p_step_once) else $error("step flag outlived its scan");

  property p_ro_words;
    wr && (paddr == ADDR_ARITH) && !flag_update |=> $stable(arith_word[7:3]);
  endproperty
  a_ro_words: assert property (p_ro_words) else $error("write altered read-only word");

  property p_out_off;
    ctrl_reg[BIT_OUT_OFF] |=> out_pins == RST_WORD && inhibit_indicator;
  endproperty
  a_out_off: assert property (p_out_off) else $error("outputs live while output-off set");

  property p_run_release;
    entering_run |=> fset_reg == RST_WORD && frst_reg == RST_WORD;
  endproperty
  a_run_release: assert property (p_run_release) else $error("forcing kept on entering run");

  property p_hold_force;
    prog_to_mon && ctrl_reg[BIT_FORCE_HOLD] && !wr |=> $stable(fset_reg) && $stable(frst_reg);
  endproperty
  a_hold_force: assert property (p_hold_force) else $error("held forcing lost");

  property p_force_level;
    fset_reg != RST_WORD && !(start_stop && !ctrl_reg[BIT_IO_HOLD]) |=>
      (image_reg & $past(fset_reg)) == $past(fset_reg);
  endproperty
  a_force_level: assert property (p_force_level) else $error("forced bit not high in image");

  property p_pio_alarm;
    pulse_io_error |=> instr_word[15] && fatal_alarm_code == PULSE_IO_ALARM;
  endproperty
  a_pio_alarm: assert property (p_pio_alarm) else $error("pulse error not reported");

  property p_zero_equal;
    flag_update && result_zero_in |=> eq_reg && arith_word[6];
  endproperty
  a_zero_equal: assert property (p_zero_equal) else $error("zero result left equal clear");

  property p_suppress;
    suppress_reg[BIT_SUP_BATT] && $past(suppress_reg[BIT_SUP_BATT]) |-> !error_word[BIT_BATT_LOW];
  endproperty
  a_suppress: assert property (p_suppress) else $error("suppressed battery error shown");

  property p_io_reset;
    start_stop && !ctrl_reg[BIT_IO_HOLD] |=> io_area_reset && image_reg == RST_WORD;
  endproperty
  a_io_reset: assert property (p_io_reset) else $error("I/O area kept without hold");

  property p_retain;
    power_up_evt && retain_reg && !wr |=> $stable(ctrl_reg[BIT_IO_HOLD:BIT_FORCE_HOLD]);
  endproperty
  a_retain: assert property (p_retain) else $error("hold bits lost despite retention");

  c_run_entry: cover property (entering_run && fset_reg != RST_WORD);
  c_out_off: cover property ($rose(inhibit_indicator));
  c_step: cover property (step_start ##[1:20] scan_end);
  c_pio: cover property (pulse_io_error ##[1:20] error_clear);

endmodule : status_flag_words

`default_nettype wire

// [dv/status_flag_words_tb_top.sv]
// Self-checking testbench for the status flag word bank, driven through APB tasks.
// Assumes the flag package and the bank module are compiled first.
`default_nettype none

module status_flag_words_tb_top
  import status_flag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals; every stimulus idle at time zero except presetn, held low, and battery_low_pin, held high.
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, d0, d1, d2;
  run_mode_t mode_sel = MODE_PROGRAM;
  logic power_up_evt = 1'b0, scan_end = 1'b0, flag_update = 1'b0, overflow_in = 1'b0, underflow_in = 1'b0;
  logic exec_error_in = 1'b0, carry_in = 1'b0, greater_in = 1'b0, equal_in = 1'b0, less_in = 1'b0;
  logic result_zero_in = 1'b0, diff_mon_start = 1'b0, diff_mon_done = 1'b0, step_start = 1'b0;
  logic hex_keypad_active = 1'b0, seven_segment_active = 1'b0, digit_switch_active = 1'b0;
  logic pulse_io_error = 1'b0, error_clear = 1'b0, battery_low_pin = 1'b1, cycle_overrun = 1'b0;
  logic prog_out_we = 1'b0, inhibit_indicator, io_area_reset;
  logic [15:0] prog_out = 16'h0000, out_pins;
  logic [7:0] fatal_alarm_code;
  int err_count = 0, checks = 0;

  // A short tick keeps the 20 ms wave a few cycles long: 4 cycles per tick.
  status_flag_words #(.TICK_LEN(4)) i_status_flag_words (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .mode_sel, .power_up_evt, .scan_end, .flag_update,
    .overflow_in, .underflow_in, .exec_error_in, .carry_in, .greater_in, .equal_in, .less_in,
    .result_zero_in, .diff_mon_start, .diff_mon_done, .step_start, .hex_keypad_active,
    .seven_segment_active, .digit_switch_active, .pulse_io_error, .error_clear, .battery_low_pin,
    .cycle_overrun, .prog_out_we, .prog_out, .out_pins, .inhibit_indicator, .io_area_reset,
    .fatal_alarm_code);

  // The 50 MHz clock.
  always #10 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts any mismatch.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer: setup, then access held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic se);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Prints the verdict and ends the run.
  task automatic results();
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // Cuts a hang short.
  initial begin
    #200us;
    err_count++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence of scenarios.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Read setups 4 cycles apart see the fast wave inverted and the minute wave steady.
    apb(1'b0, ADDR_INSTR, 32'h0, d0, e);
    @(posedge pclk);
    apb(1'b0, ADDR_INSTR, 32'h0, d1, e);
    check((d0 ^ d1) & 32'h3, 32'h2);
    // Setups 20 and 40 cycles apart on the second pulse word.
    apb(1'b0, ADDR_ARITH, 32'h0, d0, e);
    repeat (17) @(posedge pclk);
    apb(1'b0, ADDR_ARITH, 32'h0, d1, e);
    repeat (17) @(posedge pclk);
    apb(1'b0, ADDR_ARITH, 32'h0, d2, e);
    check((d0 ^ d1) & 32'h1, 32'h1);
    check((d0 ^ d2) & 32'h7, 32'h2);
    // First result: overflow, error, carry, greater.
    @(posedge pclk);
    {overflow_in, exec_error_in, carry_in, greater_in, flag_update} <= 5'h1f;
    @(posedge pclk);
    {overflow_in, exec_error_in, carry_in, greater_in, flag_update} <= 5'h00;
    apb(1'b0, ADDR_ARITH, 32'h0, d0, e);
    check(d0 & 32'hf8, 32'h38);
    apb(1'b0, ADDR_INSTR, 32'h0, d0, e);
    check(d0 & 32'h30, 32'h10);
    // Second result: underflow, less and a zero result replace the first.
    {underflow_in, less_in, result_zero_in, flag_update} <= 4'hf;
    @(posedge pclk);
    {underflow_in, less_in, result_zero_in, flag_update} <= 4'h0;
    apb(1'b0, ADDR_INSTR, 32'h0, d0, e);
    check(d0 & 32'h30, 32'h20);
    // Program writes to read-only words change nothing; an unmapped word errors.
    apb(1'b1, ADDR_ARITH, 32'hffff, d0, e);
    apb(1'b1, ADDR_RO_LOW, 32'hffff, d0, e);
    apb(1'b0, ADDR_RO_LOW, 32'h0, d0, e);
    check(d0, 32'h0);
    apb(1'b0, ADDR_ARITH, 32'h0, d0, e);
    check(d0 & 32'hf8, 32'hc0);
    apb(1'b0, 12'h410, 32'h0, d0, e);
    check({31'h0, e}, 32'h1);
    // Each busy bit follows its instruction alone.
    for (int i = 0; i < 3; i++) begin
      {digit_switch_active, seven_segment_active, hex_keypad_active} <= 3'(1 << i);
      apb(1'b0, ADDR_INSTR, 32'h0, d0, e);
      check(d0 & 32'h700, 32'(1 << (8 + i)));
    end
    // Step flag, monitor done and pulse error.
    {step_start, diff_mon_done, pulse_io_error, hex_keypad_active} <= 4'he;
    @(posedge pclk);
    {step_start, diff_mon_done, pulse_io_error} <= 3'h0;
    apb(1'b0, ADDR_INSTR, 32'h0, d0, e);
    check(d0 & 32'h80c0, 32'h80c0);
    check({24'h0, fatal_alarm_code}, 32'h9c);
    scan_end <= 1'b1;
    @(posedge pclk);
    scan_end <= 1'b0;
    apb(1'b0, ADDR_INSTR, 32'h0, d0, e);
    check(d0 & 32'h80, 32'h0);
    // Battery and overrun errors show, then vanish once suppressed.
    cycle_overrun <= 1'b1;
    @(posedge pclk);
    cycle_overrun <= 1'b0;
    apb(1'b0, ADDR_ERROR, 32'h0, d0, e);
    check(d0 & 32'h3ff, 32'h39c);
    apb(1'b1, ADDR_SUPPRESS, 32'h3, d0, e);
    apb(1'b0, ADDR_ERROR, 32'h0, d0, e);
    check(d0 & 32'h300, 32'h0);
    // Output-off blanks a program write and lights the lamp.
    apb(1'b1, ADDR_CONTROL, 32'h8000, d0, e);
    {prog_out_we, prog_out} <= 17'h100ff;
    @(posedge pclk);
    prog_out_we <= 1'b0;
    repeat (3) @(posedge pclk);
    check({15'h0, inhibit_indicator, out_pins}, 32'h10000);
    apb(1'b1, ADDR_CONTROL, 32'h1000, d0, e);
    repeat (3) @(posedge pclk);
    check({15'h0, inhibit_indicator, out_pins}, 32'h000ff);
    // Entering run releases a force-set mask.
    apb(1'b1, ADDR_FORCE_SET, 32'h1, d0, e);
    mode_sel <= MODE_RUN;
    repeat (2) @(posedge pclk);
    apb(1'b0, ADDR_FORCE_SET, 32'h0, d0, e);
    check(d0, 32'h0);
    // Leaving run without I/O hold pulses the area reset, then the pins clear.
    apb(1'b1, ADDR_CONTROL, 32'h0800, d0, e);
    mode_sel <= MODE_PROGRAM;
    @(posedge pclk);
    @(negedge pclk);
    check({15'h0, io_area_reset, out_pins}, 32'h100ff);
    @(negedge pclk);
    check({15'h0, io_area_reset, out_pins}, 32'h0);
    // Force hold keeps a mask into monitor; its bit stays high after run releases it.
    apb(1'b1, ADDR_FORCE_SET, 32'h4, d0, e);
    mode_sel <= MODE_MONITOR;
    apb(1'b0, ADDR_FORCE_SET, 32'h0, d0, e);
    check(d0, 32'h4);
    mode_sel <= MODE_RUN;
    repeat (3) @(posedge pclk);
    check({16'h0, out_pins}, 32'h4);
    // Power-up drops the hold bits unless retention is set.
    power_up_evt <= 1'b1;
    @(posedge pclk);
    power_up_evt <= 1'b0;
    apb(1'b0, ADDR_CONTROL, 32'h0, d0, e);
    check(d0, 32'h0);
    apb(1'b1, ADDR_RETAIN, 32'h1, d0, e);
    apb(1'b1, ADDR_CONTROL, 32'h1800, d0, e);
    power_up_evt <= 1'b1;
    @(posedge pclk);
    power_up_evt <= 1'b0;
    apb(1'b0, ADDR_CONTROL, 32'h0, d0, e);
    check(d0, 32'h1800);
    results();
  end

endmodule : status_flag_words_tb_top

`default_nettype wire
